// ---- ser_pkg.sv ----
package ser_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	// sequence and timeout timers count in ticks of this size
	localparam int TICK_US = 10;
	localparam int TICK_CYC = TICK_US * CYC_PER_US;
	localparam int FETCH_US = 20;
	localparam int FETCH_CYC = FETCH_US * CYC_PER_US;
	localparam int BYTE_US = 250;
	localparam int BYTE_CYC_DEF = BYTE_US * CYC_PER_US;

	localparam int N_SUP = 8;
	localparam int N_GPI = 4;
	localparam int N_IN = N_SUP + N_GPI + 1;
	localparam int N_PDO = 8;
	localparam int ST_W = 6;
	localparam int DLY_W = 16;
	localparam int SEL_W = 4;
	localparam int ADDR_W = 12;

	// live / snapshot status layout
	localparam int L_UV = 0;
	localparam int L_OV = 8;
	localparam int L_GPI = 16;
	localparam int L_LIM = 20;
	localparam int LIVE_W = 21;
	localparam int SN_CAUSE = 21;
	localparam int SN_PREV = 23;

	// status and control register layout
	localparam int S_RUN = 8;
	localparam int S_FETCH = 9;
	localparam int S_REC_BUSY = 10;
	localparam int S_REC_FULL = 11;
	localparam int S_SCAN = 12;
	localparam int S_SLOT = 16;
	localparam int C_RUN = 0;
	localparam int C_REC_RST = 1;

	// state definition word, three bus words per state
	localparam int P_SEQ_SEL = 0;
	localparam int P_SEQ_LVL = 4;
	localparam int P_SEQ_DLY = 5;
	localparam int P_TMO_DLY = 21;
	localparam int P_MON_MASK = 37;
	localparam int P_MON_EXP = 50;
	localparam int P_LATCH = 63;
	localparam int P_NXT_SEQ = 64;
	localparam int P_NXT_TMO = 70;
	localparam int P_NXT_MON = 76;
	localparam int P_PDO = 82;
	localparam int P_REC = 90;
	localparam int DEF_W = 96;
	localparam logic [1:0] TBL_LAST_WORD = 2'h2;

	localparam logic [15:0] REC_BASE = 16'hf980;
	localparam logic [3:0] REC_LAST_SLOT = 4'hf;
	localparam logic [2:0] REC_LAST_BYTE = 3'h7;
	localparam int REC_FLAG = 7;
	localparam int REC_BYTES = 8;

	localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] REG_FAULT_LATCH_LOW = 12'h008;
	localparam logic [ADDR_W-1:0] REG_FAULT_LATCH_HIGH = 12'h00c;
	localparam logic [ADDR_W-1:0] REG_LIVE_STATUS = 12'h010;
	localparam logic [ADDR_W-1:0] REG_SNAP_STATUS = 12'h014;
	localparam logic [ADDR_W-1:0] REG_STATE_TABLE = 12'h100;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {ENG_STOP, ENG_FETCH, ENG_RUN} ser_eng_type;
	typedef enum logic [2:0] {
		REC_SCAN, REC_WAIT, REC_CHK, REC_IDLE, REC_WR, REC_FULL
	} ser_rec_type;
	typedef enum logic [1:0] {
		CAUSE_NONE, CAUSE_SEQ, CAUSE_TMO, CAUSE_MON
	} ser_cause_type;
endpackage : ser_pkg

// ---- ser_seq_recorder.sv ----
// What this block does
// - sequence exit watches one selected input level
// - qualifying delay restarts whenever input leaves level
// - monitor exit: wide OR of enabled deviations
// - monitor exit has no programmable delay
// - each exit waits a state fetch latency
// - timeout exit after programmed per-state time
// - driver outputs fixed per state on entry
// - fault latch: one sticky bit per input
// - latching enabled per state definition
// - live status follows the inputs continuously
// - snapshot status captured at each state change
// - sixteen eight-byte slots from f980 to f9ff
// - record written on entering a marked state
// - record: flag, state, cause, status, checksum
// - eight bytes, one byte per write time
// - a started record finishes before another
// - power-on scan finds first slot flagged unused
// - program only; stop writing when all full
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
module ser_seq_recorder
	import ser_pkg::*;
#(
	parameter int NUM_STATES = 63,
	parameter int BYTE_CYC   = BYTE_CYC_DEF
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [N_SUP-1:0]  detector_uv,
	input  wire logic [N_SUP-1:0]  detector_ov,
	input  wire logic [N_GPI-1:0]  digital_input,
	input  wire logic              converter_limit,
	output logic [N_PDO-1:0]       programmable_driver_output,
	output logic                   nvm_rd,
	output logic                   nvm_wr,
	output logic [15:0]            nvm_addr,
	output logic [7:0]             nvm_wdata,
	input  wire logic [7:0]        nvm_rdata
);
	localparam logic [ST_W:0] NS_LIM = (ST_W + 1)'(NUM_STATES);
	localparam logic [7:0] NS_IDX = 8'(NUM_STATES);
	localparam logic [15:0] TICK_END = 16'(TICK_CYC - 1);
	localparam logic [15:0] FETCH_END = 16'(FETCH_CYC - 1);
	localparam logic [15:0] BYTE_END = 16'(BYTE_CYC - 1);
	localparam logic [15:0] SAT = 16'hffff;

	typedef struct packed {
		logic [N_SUP-1:0]  uv_s1;
		logic [N_SUP-1:0]  uv_s2;
		logic [N_SUP-1:0]  ov_s1;
		logic [N_SUP-1:0]  ov_s2;
		logic [N_GPI-1:0]  gpi_s1;
		logic [N_GPI-1:0]  gpi_s2;
		logic              lim_s1;
		logic              lim_s2;
		ser_eng_type       eng;
		ser_rec_type       rec;
		logic              run;
		logic              rec_rst;
		logic [ST_W-1:0]   cur;
		logic [ST_W-1:0]   next;
		logic [15:0]       fcnt;
		logic [15:0]       div;
		logic [DLY_W-1:0]  seq_cnt;
		logic [DLY_W-1:0]  tmo_cnt;
		logic [N_PDO-1:0]  pdo;
		logic [N_IN-1:0]   fault;
		logic [LIVE_W-1:0] snap;
		logic [ST_W-1:0]   snap_prev;
		ser_cause_type     snap_cause;
		logic [3:0]        slot;
		logic [2:0]        byte_n;
		logic [15:0]       wcnt;
		logic [ST_W-1:0]   r_prev;
		ser_cause_type     r_cause;
		logic [LIVE_W-1:0] r_stat;
		logic              nvm_rd;
		logic              nvm_wr;
		logic [15:0]       nvm_addr;
		logic [7:0]        nvm_wdata;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic [NUM_STATES-1:0][DEF_W-1:0] defs;
	} ser_state_type;

	ser_state_type q;
	ser_state_type next_q;

	function automatic logic tbl_ok(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - REG_STATE_TABLE;
		return a >= REG_STATE_TABLE && off[ADDR_W-1:4] < NS_IDX
			&& off[3:2] <= TBL_LAST_WORD;
	endfunction : tbl_ok

	always_comb begin
		ser_state_type n;
		logic [DEF_W-1:0] cd;
		logic [DEF_W-1:0] nd;
		logic [N_IN-1:0] se_in;
		logic [15:0] se16;
		logic [N_IN-1:0] dev;
		logic [LIVE_W-1:0] live;
		logic tick;
		logic match;
		logic seq_hit;
		logic tmo_hit;
		logic mon_hit;
		logic [DLY_W-1:0] tdly;
		logic [REC_BYTES-1:0][7:0] rb;
		logic [2:0] bsel;
		logic [ADDR_W-1:0] off;
		logic [7:0] ti;
		logic [1:0] tw;
		logic [31:0] rword;
		n = q;
		cd = '0;
		nd = '0;
		rword = '0;
		n.nvm_rd = 1'b0;
		n.nvm_wr = 1'b0;

		n.uv_s1 = detector_uv;
		n.uv_s2 = q.uv_s1;
		n.ov_s1 = detector_ov;
		n.ov_s2 = q.ov_s1;
		n.gpi_s1 = digital_input;
		n.gpi_s2 = q.gpi_s1;
		n.lim_s1 = converter_limit;
		n.lim_s2 = q.lim_s1;

		tick = (q.div == TICK_END);
		n.div = tick ? '0 : q.div + 16'h1;

		live = {q.lim_s2, q.gpi_s2, q.ov_s2, q.uv_s2};
		se_in = {q.lim_s2, q.gpi_s2, ~(q.uv_s2 | q.ov_s2)};
		se16 = {3'h0, se_in};
		if ({1'b0, q.cur} < NS_LIM) begin
			cd = q.defs[q.cur];
		end
		if ({1'b0, q.next} < NS_LIM) begin
			nd = q.defs[q.next];
		end

		// sequence detector
		match = se16[cd[P_SEQ_SEL +: SEL_W]] == cd[P_SEQ_LVL];
		seq_hit = match && q.seq_cnt >= cd[P_SEQ_DLY +: DLY_W];
		// timeout detector, zero delay disables it
		tdly = cd[P_TMO_DLY +: DLY_W];
		tmo_hit = tdly != '0 && q.tmo_cnt >= tdly;
		// monitor: no timer in this path at all
		dev = cd[P_MON_MASK +: N_IN] & (se_in ^ cd[P_MON_EXP +: N_IN]);
		mon_hit = |dev;

		// record image; byte 0 carries the used flag
		rb[0] = {1'b0, 1'b1, q.r_prev};
		rb[1] = {5'h0, q.r_stat[L_LIM], q.r_cause};
		rb[2] = q.r_stat[L_UV +: N_SUP];
		rb[3] = q.r_stat[L_OV +: N_SUP];
		rb[4] = {4'h0, q.r_stat[L_GPI +: N_GPI]};
		rb[5] = 8'h00;
		rb[6] = 8'h00;
		rb[7] = 8'h00 - (rb[0] + rb[1] + rb[2] + rb[3] + rb[4]
			+ rb[5] + rb[6]);
		// flag byte goes last so a torn record still reads as free
		bsel = q.byte_n + 3'h1;

		// recorder
		if (q.rec_rst && q.rec != REC_WR) begin
			n.rec_rst = 1'b0;
			n.slot = '0;
			n.rec = REC_SCAN;
		end else begin
			case (q.rec)
				REC_SCAN: begin
					n.nvm_addr = REC_BASE + 16'({q.slot, 3'h0});
					n.nvm_rd = 1'b1;
					n.rec = REC_WAIT;
				end
				REC_WAIT: begin
					n.rec = REC_CHK;
				end
				REC_CHK: begin
					if (nvm_rdata[REC_FLAG]) begin
						n.rec = REC_IDLE;
					end else if (q.slot == REC_LAST_SLOT) begin
						n.rec = REC_FULL;
					end else begin
						n.slot = q.slot + 4'h1;
						n.rec = REC_SCAN;
					end
				end
				REC_WR: begin
					if (q.wcnt == '0) begin
						n.nvm_wr = 1'b1;
						n.nvm_addr = REC_BASE + 16'({q.slot, bsel});
						n.nvm_wdata = rb[bsel];
					end
					if (q.wcnt == BYTE_END) begin
						n.wcnt = '0;
						if (q.byte_n == REC_LAST_BYTE) begin
							if (q.slot == REC_LAST_SLOT) begin
								n.rec = REC_FULL;
							end else begin
								n.slot = q.slot + 4'h1;
								n.rec = REC_IDLE;
							end
						end else begin
							n.byte_n = q.byte_n + 3'h1;
						end
					end else begin
						n.wcnt = q.wcnt + 16'h1;
					end
				end
				REC_IDLE, REC_FULL: begin
				end
				default: begin
					n.rec = REC_SCAN;
				end
			endcase
		end

		// write channel: address and data taken in either order
		if (q.awready && s_axi_awvalid) begin
			n.awaddr = s_axi_awaddr;
			n.awready = 1'b0;
		end
		if (q.wready && s_axi_wvalid) begin
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
			n.wready = 1'b0;
		end
		if (!q.awready && !q.wready && !q.bvalid) begin
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			off = q.awaddr - REG_STATE_TABLE;
			ti = off[ADDR_W-1:4];
			tw = off[3:2];
			case (q.awaddr)
				REG_CTRL: begin
					if (q.wstrb[0]) begin
						n.run = q.wdata[C_RUN];
						// a request taken by the recorder this cycle must not
						// be revived by an unrelated control write
						n.rec_rst = n.rec_rst | q.wdata[C_REC_RST];
					end
				end
				REG_FAULT_LATCH_LOW: begin
					if (q.wstrb[0]) begin
						n.fault[N_SUP-1:0] = q.fault[N_SUP-1:0]
							& ~q.wdata[N_SUP-1:0];
					end
				end
				REG_FAULT_LATCH_HIGH: begin
					if (q.wstrb[0]) begin
						n.fault[N_IN-1:N_SUP] = q.fault[N_IN-1:N_SUP]
							& ~q.wdata[N_IN-N_SUP-1:0];
					end
				end
				REG_STATUS, REG_LIVE_STATUS, REG_SNAP_STATUS: begin
				end
				default: begin
					if (tbl_ok(q.awaddr)) begin
						for (int b = 0; b < 4; b++) begin
							if (q.wstrb[b]) begin
								n.defs[ti][tw * 32 + b * 8 +: 8] =
									q.wdata[b * 8 +: 8];
							end
						end
					end else begin
						n.bresp = RESP_DECERR;
					end
				end
			endcase
		end
		if (q.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end

		// read channel
		if (q.arready && s_axi_arvalid) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			off = s_axi_araddr - REG_STATE_TABLE;
			ti = off[ADDR_W-1:4];
			tw = off[3:2];
			case (s_axi_araddr)
				REG_CTRL: begin
					rword[C_RUN] = q.run;
					rword[C_REC_RST] = q.rec_rst;
				end
				REG_STATUS: begin
					rword[ST_W-1:0] = q.cur;
					rword[S_RUN] = q.eng == ENG_RUN;
					rword[S_FETCH] = q.eng == ENG_FETCH;
					rword[S_REC_BUSY] = q.rec == REC_WR;
					rword[S_REC_FULL] = q.rec == REC_FULL;
					rword[S_SCAN] = q.rec == REC_SCAN
						|| q.rec == REC_WAIT || q.rec == REC_CHK;
					rword[S_SLOT +: 4] = q.slot;
				end
				REG_FAULT_LATCH_LOW: begin
					rword[N_SUP-1:0] = q.fault[N_SUP-1:0];
				end
				REG_FAULT_LATCH_HIGH: begin
					rword[N_IN-N_SUP-1:0] = q.fault[N_IN-1:N_SUP];
				end
				REG_LIVE_STATUS: begin
					rword[LIVE_W-1:0] = live;
				end
				REG_SNAP_STATUS: begin
					rword[LIVE_W-1:0] = q.snap;
					rword[SN_CAUSE +: 2] = q.snap_cause;
					rword[SN_PREV +: ST_W] = q.snap_prev;
				end
				default: begin
					if (tbl_ok(s_axi_araddr)) begin
						rword = q.defs[ti][tw * 32 +: 32];
					end else begin
						n.rresp = RESP_DECERR;
					end
				end
			endcase
			n.rdata = rword;
		end
		if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end

		// sequencing engine
		case (q.eng)
			ENG_STOP: begin
				if (q.run) begin
					n.next = '0;
					n.fcnt = '0;
					n.eng = ENG_FETCH;
				end
			end
			ENG_FETCH: begin
				if (q.fcnt == FETCH_END) begin
					n.cur = q.next;
					n.pdo = nd[P_PDO +: N_PDO];
					n.seq_cnt = '0;
					n.tmo_cnt = '0;
					n.eng = ENG_RUN;
					// a write in progress drops this record
					if (nd[P_REC] && q.rec == REC_IDLE
						&& !q.rec_rst) begin
						n.rec = REC_WR;
						n.byte_n = '0;
						n.wcnt = '0;
						n.r_prev = q.snap_prev;
						n.r_cause = q.snap_cause;
						n.r_stat = q.snap;
					end
				end else begin
					n.fcnt = q.fcnt + 16'h1;
				end
			end
			ENG_RUN: begin
				if (cd[P_LATCH]) begin
					n.fault = n.fault | dev;
				end
				if (!match) begin
					n.seq_cnt = '0;
				end else if (tick && q.seq_cnt != SAT) begin
					n.seq_cnt = q.seq_cnt + 16'h1;
				end
				if (tick && q.tmo_cnt != SAT) begin
					n.tmo_cnt = q.tmo_cnt + 16'h1;
				end
				if (mon_hit || tmo_hit || seq_hit) begin
					n.snap = live;
					n.snap_prev = q.cur;
					n.fcnt = '0;
					n.eng = ENG_FETCH;
					if (mon_hit) begin
						n.snap_cause = CAUSE_MON;
						n.next = cd[P_NXT_MON +: ST_W];
					end else if (tmo_hit) begin
						n.snap_cause = CAUSE_TMO;
						n.next = cd[P_NXT_TMO +: ST_W];
					end else begin
						n.snap_cause = CAUSE_SEQ;
						n.next = cd[P_NXT_SEQ +: ST_W];
					end
				end else if (!q.run) begin
					n.eng = ENG_STOP;
				end
			end
			default: begin
				n.eng = ENG_STOP;
			end
		endcase

		if (!aresetn) begin
			n = '0;
			n.awready = 1'b1;
			n.wready = 1'b1;
			n.arready = 1'b1;
		end
		next_q = n;
	end

	always_ff @(posedge aclk) begin
		q <= next_q;
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;
	assign programmable_driver_output = q.pdo;
	assign nvm_rd = q.nvm_rd;
	assign nvm_wr = q.nvm_wr;
	assign nvm_addr = q.nvm_addr;
	assign nvm_wdata = q.nvm_wdata;
endmodule : ser_seq_recorder

// ---- ser_seq_recorder_assertions.sv ----
module ser_seq_recorder_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        nvm_rd,
	input wire logic        nvm_wr,
	input wire logic [15:0] nvm_addr,
	input wire logic [7:0]  nvm_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] last_off;

	// bytes go 1..7 then 0, so every write is one past the last one
	always_ff @(posedge aclk) begin
		if (!aresetn)
			last_off <= 3'h0;
		else if (nvm_wr)
			last_off <= nvm_addr[2:0];
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		!s_axi_awready ##1 s_axi_bvalid;
	endsequence
	sequence s_flag_byte;
		nvm_wr && nvm_addr[2:0] == 3'h0;
	endsequence

	property p_byte_order;
		nvm_wr |-> nvm_addr[2:0] == 3'(last_off + 3'h1);
	endproperty
	property p_flag_byte;
		s_flag_byte |-> nvm_wdata[7:6] == 2'h1;
	endproperty
	property p_byte_gap;
		nvm_wr |=> !nvm_wr [*8];
	endproperty
	property p_scan_read;
		nvm_rd |-> nvm_addr[15:7] == 9'h1f3 && nvm_addr[2:0] == 3'h0
			##1 !nvm_rd;
	endproperty
	property p_wr_area;
		nvm_wr |-> nvm_addr[15:7] == 9'h1f3 && !nvm_rd;
	endproperty
	property p_wr_answer;
		s_wr_taken |=> s_wr_answer;
	endproperty
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty

	a_byte_order: assert property (p_byte_order)
		else $error("record byte order broken");
	a_flag_byte: assert property (p_flag_byte)
		else $error("flag byte not cleared");
	a_byte_gap: assert property (p_byte_gap)
		else $error("record bytes too close");
	a_scan_read: assert property (p_scan_read)
		else $error("scan read outside slot flags");
	a_wr_area: assert property (p_wr_area)
		else $error("record write outside area");
	a_wr_answer: assert property (p_wr_answer)
		else $error("write response late");
	a_r_answer: assert property (p_r_answer)
		else $error("read data late");
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
endmodule : ser_seq_recorder_checker

bind ser_seq_recorder ser_seq_recorder_checker u_chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.nvm_rd(nvm_rd),
	.nvm_wr(nvm_wr),
	.nvm_addr(nvm_addr),
	.nvm_wdata(nvm_wdata)
);

// ---- ser_nvm_model.sv ----
module ser_nvm_model #(
	parameter int N_USED = 0
) (
	input  wire logic        aclk,
	input  wire logic        nvm_rd,
	input  wire logic        nvm_wr,
	input  wire logic [15:0] nvm_addr,
	input  wire logic [7:0]  nvm_wdata,
	output logic [7:0]       nvm_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [128];

	initial begin
		for (int i = 0; i < 128; i++)
			mem[i] = 8'hff; // area starts erased
		for (int i = 0; i < N_USED; i++)
			mem[8 * i] = 8'h41;
		nvm_rdata = 8'h00;
	end

	// data stands in the cycle after the read pulse, when the scan samples
	// it; outside that slot the lines are not held: toggle them
	always @(posedge aclk) begin
		nvm_rdata <= nvm_rd ? mem[nvm_addr[6:0]] : ~nvm_rdata;
		if (nvm_wr && nvm_addr[15:7] == 9'h1f3)
			mem[nvm_addr[6:0]] <= mem[nvm_addr[6:0]] & nvm_wdata;
	end
endmodule : ser_nvm_model

// ---- ser_seq_recorder_bench.sv ----
module ser_seq_recorder_bench
	import ser_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, lim, nrd, nwr;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [7:0]  uv, ov, pdo, nwd, nrdat;
	logic [3:0]  gpi;
	logic [15:0] naddr;
	int          n_errors = 0;
	int          num_checks = 0;

	ser_seq_recorder #(.NUM_STATES(4), .BYTE_CYC(20)) uut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.detector_uv(uv), .detector_ov(ov), .digital_input(gpi),
		.converter_limit(lim), .programmable_driver_output(pdo),
		.nvm_rd(nrd), .nvm_wr(nwr), .nvm_addr(naddr),
		.nvm_wdata(nwd), .nvm_rdata(nrdat)
	);
	ser_nvm_model #(.N_USED(14)) nvm (
		.aclk(aclk), .nvm_rd(nrd), .nvm_wr(nwr), .nvm_addr(naddr),
		.nvm_wdata(nwd), .nvm_rdata(nrdat)
	);

	task automatic end_sim();
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", nm, e, g);
			n_errors++;
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		// let an edge pass so a following call never re-raises bready
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'h0;
		end while (!rvalid);
		d = rdata;
		rready <= 1'h0;
		@(posedge aclk);
	endtask : rd

	task automatic rchk(input string nm, input logic [11:0] a,
		input logic [31:0] m, e);
		logic [31:0] d;
		rd(a, d);
		chk(nm, e, d & m);
	endtask : rchk

	task automatic wait_pdo(input logic [7:0] v, output int n);
		n = 0;
		while (pdo !== v && n < 9000) begin
			@(posedge aclk);
			n++;
		end
		chk("pdo", 32'(v), 32'(pdo));
	endtask : wait_pdo

	function automatic logic [95:0] mk(input logic [3:0] sel,
		input logic [15:0] sd, td, input logic [12:0] mm,
		input logic lt, rec, input logic [5:0] ns, nt, nm,
		input logic [7:0] po);
		logic [95:0] d;
		d = '0;
		d[P_SEQ_SEL+:4] = sel;
		d[P_SEQ_LVL] = 1'h1;
		d[P_SEQ_DLY+:16] = sd;
		d[P_TMO_DLY+:16] = td;
		d[P_MON_MASK+:13] = mm;
		d[P_MON_EXP+:13] = mm;
		d[P_LATCH] = lt;
		d[P_NXT_SEQ+:6] = ns;
		d[P_NXT_TMO+:6] = nt;
		d[P_NXT_MON+:6] = nm;
		d[P_PDO+:8] = po;
		d[P_REC] = rec;
		return d;
	endfunction : mk

	task automatic t_setup();
		logic [31:0] d;
		logic [95:0] st [4];
		int          n;
		n = 0;
		do begin
			rd(REG_STATUS, d);
			n++;
		end while (d[S_SCAN] && n < 200);
		chk("slot", 32'he, 32'(d[S_SLOT+:4]));
		rd(12'h01c, d);
		chk("rresp", 32'(RESP_DECERR), 32'(rresp));
		wr(12'h01c, 32'h1);
		chk("bresp", 32'(RESP_DECERR), 32'(bresp));
		uv <= 8'h5a;
		ov <= 8'ha5;
		gpi <= 4'h6;
		lim <= 1'h1;
		repeat (6) @(posedge aclk);
		rchk("live", REG_LIVE_STATUS, 32'h1fffff, 32'h16a55a);
		uv <= 8'h00;
		ov <= 8'h00;
		gpi <= 4'h0;
		lim <= 1'h0;
		st[0] = mk(4'h8, 16'h2, 0, 0, 0, 0, 6'h1, 0, 0, 8'h11);
		st[1] = mk(4'hd, 0, 0, 13'h1, 1, 0, 0, 0, 6'h2, 8'h22);
		// long enough for a whole record before the next one
		st[2] = mk(4'hd, 0, 16'h14, 0, 0, 1, 0, 6'h3, 0, 8'h44);
		st[3] = mk(4'hd, 0, 0, 0, 0, 1, 0, 0, 0, 8'h88);
		for (int s = 0; s < 4; s++)
			for (int w = 0; w < 3; w++)
				wr(REG_STATE_TABLE + 12'(16 * s + 4 * w), st[s][32*w+:32]);
		rchk("table", 12'h118, 32'hffffffff, st[1][64+:32]);
	endtask : t_setup

	task automatic t_seq();
		int n;
		wr(REG_CTRL, 32'h1);
		wait_pdo(8'h11, n);
		gpi <= 4'h1;
		repeat (100) @(posedge aclk);
		gpi <= 4'h0;
		repeat (300) @(posedge aclk);
		gpi <= 4'h1;
		repeat (150) @(posedge aclk);
		rchk("hold", REG_STATUS, 32'h33f, 32'h100);
		wait_pdo(8'h22, n);
		chk("seqdly", 32'h1, 32'(n > 440 && n < 700));
	endtask : t_seq

	task automatic t_mon();
		int n;
		uv <= 8'h01;
		wait_pdo(8'h44, n);
		chk("mondly", 32'h1, 32'(n >= 400 && n < 420));
		rchk("latch", REG_FAULT_LATCH_LOW, 32'hff, 32'h01);
		rchk("snap", REG_SNAP_STATUS, 32'h1fffffff, 32'he10001);
		uv <= 8'h00;
		ov <= 8'h08;
		repeat (8) @(posedge aclk);
		rchk("nolatch", REG_FAULT_LATCH_LOW, 32'hff, 32'h01);
		rchk("snap2", REG_SNAP_STATUS, 32'h1fffffff, 32'he10001);
		ov <= 8'h00;
		wr(REG_FAULT_LATCH_LOW, 32'h1);
		rchk("w1c", REG_FAULT_LATCH_LOW, 32'hff, 32'h00);
	endtask : t_mon

	task automatic t_rec();
		logic [7:0]  e [8];
		logic [31:0] d;
		int          n;
		e = '{8'h41, 8'h03, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++)
			e[7] = e[7] - e[i];
		wait_pdo(8'h88, n);
		n = 0;
		do begin
			rd(REG_STATUS, d);
			n++;
		end while (d[S_REC_BUSY] && n < 200);
		for (int i = 0; i < 8; i++)
			chk("rec", 32'(e[i]), 32'(nvm.mem[7'h70 + 7'(i)]));
		chk("rec15", 32'h42, 32'(nvm.mem[7'h78]));
		chk("cause15", 32'h02, 32'(nvm.mem[7'h79]));
		chk("full", 32'h1, 32'(d[S_REC_FULL]));
	endtask : t_rec

	task automatic t_reuse();
		logic [31:0] d;
		int          n;
		for (int i = 0; i < 128; i++)
			nvm.mem[i] = 8'hff; // host erases the area
		wr(REG_CTRL, 32'h3);
		n = 0;
		do begin
			rd(REG_STATUS, d);
			n++;
		end while (d[S_SCAN] && n < 200);
		chk("reslot", 32'h0, 32'(d[S_SLOT+:4]));
		chk("refull", 32'h0, 32'(d[S_REC_FULL]));
		rchk("rstreq", REG_CTRL, 32'h3, 32'h1);
	endtask : t_reuse

	initial begin
		aclk = 1'h0;
		forever #25 aclk = ~aclk;
	end

	initial begin
		repeat (40000) @(posedge aclk);
		n_errors++;
		end_sim();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, lim} = '0;
		{awaddr, araddr, wdata, uv, ov, gpi} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		t_setup();
		t_seq();
		t_mon();
		t_rec();
		t_reuse();
		end_sim();
	end
endmodule : ser_seq_recorder_bench
